// ===== hdl/sdc_defs.svh
// Constants for the SPI diagnostic command decoder: words, field positions and reset values.
`ifndef SDC_DEFS_SVH
`define SDC_DEFS_SVH

`define SDC_FRAME_BITS 16
`define SDC_CNT_LAST 5'h0f
`define SDC_CNT_RST 5'h00
`define SDC_HDR_MSB 15
`define SDC_HDR_LSB 11
`define SDC_RD_PAR_BIT 10
`define SDC_WR_PAR_BIT 9
`define SDC_RD_PAR_LSB 10

`define SDC_ENTRY_WORD 16'ha35c
`define SDC_PAR_FAULT_WORD 16'h83ff
`define SDC_INV_RESP 16'h8000
`define SDC_WAIT_HI_RESP 16'h0001
`define SDC_LOCK_RESP 16'h0000
`define SDC_RESP_RST 16'h0000

`define SDC_PFX_LOCK 2'h2
`define SDC_PFX_HIGH 2'h3

`define SDC_HDR_PTR_WR 5'h09
`define SDC_HDR_PTR_RD 5'h08
`define SDC_HDR_DAT_WR 5'h0b
`define SDC_HDR_DAT_RD 5'h0a
`define SDC_HDR_ACC_RD 5'h0c

`define SDC_RHDR_PTR 5'h16
`define SDC_RHDR_DAT 5'h14
`define SDC_RHDR_ACC 5'h13
`define SDC_RMID_PTR 2'h1
`define SDC_RMID_DAT 2'h2

`define SDC_ACC_BODY_ZERO 10'h000
`define SDC_PTR_RST 8'h00
`define SDC_BYTE_RST 8'h00

`endif

// ===== hdl/sdc_pkg.sv
// Types shared by the SPI diagnostic command decoder and its link shifter.
package sdc_pkg;

  typedef enum logic [1:0] {
    SDC_ST_WAIT = 2'b00,
    SDC_ST_ACTIVE = 2'b01,
    SDC_ST_LOCKED = 2'b10
  } sdc_state_t;

  typedef struct packed {
    logic [14:0] shift;
    logic [15:0] word;
    logic tgl;
  } sdc_link_t;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic tg_s1;
    logic tg_s2;
    logic tg_seen;
    sdc_state_t st;
    logic mode;
    logic locked;
    logic par_skip;
    logic [7:0] ptr;
    logic [7:0] wdata;
    logic we;
    logic par_evt;
    logic inv_evt;
    logic [15:0] resp;
  } sdc_sys_t;

endpackage

// ===== hdl/sdc_link_shifter.sv
// SPI link shifter on the serial clock: collects 16-bit frames and serves the response bits.
`include "sdc_defs.svh"

module sdc_link_shifter (
  input wire logic spi_sclk,
  input wire logic arst_n,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic [15:0] resp_word,
  output logic spi_miso,
  output logic [15:0] frame_word,
  output logic frame_tgl
);

  sdc_pkg::sdc_link_t l_q;
  sdc_pkg::sdc_link_t l_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic clr_n;

  // The bit counter is cleared while chip select is high, since the
  // serial clock does not run between frames.
  assign clr_n = arst_n & ~spi_cs_n;

  always_comb begin
    cnt_d = cnt_q;
    if (cnt_q <= `SDC_CNT_LAST) begin
      cnt_d = cnt_q + 5'h01;
    end
  end

  always_ff @(posedge spi_sclk or negedge clr_n) begin
    if (!clr_n) begin
      cnt_q <= `SDC_CNT_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Sample on the rising edge, most significant bit first.
  always_comb begin
    l_d = l_q;
    if (cnt_q < `SDC_CNT_LAST) begin
      l_d.shift = {l_q.shift[13:0], spi_mosi};
    end else if (cnt_q == `SDC_CNT_LAST) begin
      l_d.word = {l_q.shift, spi_mosi};
      l_d.tgl = ~l_q.tgl;
    end
  end

  always_ff @(posedge spi_sclk or negedge arst_n) begin
    if (!arst_n) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // The response word only changes while chip select is high, so it is
  // stable for the whole frame; the bit moves on after each rising edge.
  // Outside a frame the line is held low so it never shows a stale bit.
  always_comb begin
    spi_miso = 1'b0;
    if (!spi_cs_n && (cnt_q <= `SDC_CNT_LAST)) begin
      spi_miso = resp_word[4'hf - cnt_q[3:0]];
    end
  end

  assign frame_word = l_q.word;
  assign frame_tgl = l_q.tgl;

endmodule

// ===== hdl/sdc_diag_decoder.sv
// SPI diagnostic mode command decoder: entry, pointer, register and acceleration commands.
`include "sdc_defs.svh"

module sdc_diag_decoder (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_we,
  input wire logic [7:0] reg_rdata,
  input wire logic [9:0] accel_data,
  output logic diag_program_mode,
  output logic entry_locked,
  output logic parity_fault,
  output logic invalid_cmd
);

  sdc_pkg::sdc_sys_t s_q;
  sdc_pkg::sdc_sys_t s_d;
  logic [15:0] link_word;
  logic link_tgl;

  // Builds a reply from header and body and sets bit ten so that the
  // whole word has odd parity.
  function automatic logic [15:0] sdc_reply(input logic [4:0] hdr, input logic [9:0] body);
    logic [15:0] w;
    w = {hdr, 1'b0, body};
    w[`SDC_RD_PAR_BIT] = ~(^w);
    return w;
  endfunction

  // Odd parity check over the fields that each command kind covers.
  function automatic logic sdc_par_ok(input logic [15:0] w, input logic is_wr);
    logic ok;
    ok = 1'b0;
    if (is_wr) begin
      ok = ^w;
    end else begin
      ok = ^w[`SDC_HDR_MSB:`SDC_RD_PAR_LSB];
    end
    return ok;
  endfunction

  sdc_link_shifter u_link (
    .spi_sclk(spi_sclk),
    .arst_n(arst_n),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .resp_word(s_q.resp),
    .spi_miso(spi_miso),
    .frame_word(link_word),
    .frame_tgl(link_tgl)
  );

  logic frame_end;
  logic new_word;
  logic [4:0] hdr;
  logic is_wr;
  logic known;
  logic par_good;

  assign hdr = link_word[`SDC_HDR_MSB:`SDC_HDR_LSB];
  assign is_wr = (hdr == `SDC_HDR_PTR_WR) || (hdr == `SDC_HDR_DAT_WR);
  assign known = is_wr || (hdr == `SDC_HDR_PTR_RD) || (hdr == `SDC_HDR_DAT_RD) ||
                 (hdr == `SDC_HDR_ACC_RD);
  assign par_good = sdc_par_ok(link_word, is_wr);

  // Chip select release seen after two synchroniser stages; the frame word
  // is quiet at that moment because the serial clock has stopped.
  assign frame_end = s_q.cs_s2 & ~s_q.cs_s3;
  assign new_word = s_q.tg_s2 != s_q.tg_seen;

  always_comb begin
    s_d = s_q;
    s_d.cs_s1 = spi_cs_n;
    s_d.cs_s2 = s_q.cs_s1;
    s_d.cs_s3 = s_q.cs_s2;
    s_d.tg_s1 = link_tgl;
    s_d.tg_s2 = s_q.tg_s1;
    s_d.we = 1'b0;
    s_d.par_evt = 1'b0;
    s_d.inv_evt = 1'b0;
    if (frame_end && new_word) begin
      s_d.tg_seen = s_q.tg_s2;
      case (s_q.st)
        sdc_pkg::SDC_ST_WAIT: begin
          if (link_word == `SDC_ENTRY_WORD) begin
            s_d.resp = ~link_word;
            s_d.st = sdc_pkg::SDC_ST_ACTIVE;
            s_d.mode = 1'b1;
          end else if (link_word[15:14] == `SDC_PFX_LOCK) begin
            s_d.resp = `SDC_LOCK_RESP;
            s_d.st = sdc_pkg::SDC_ST_LOCKED;
            s_d.locked = 1'b1;
          end else if (link_word[15:14] == `SDC_PFX_HIGH) begin
            s_d.resp = `SDC_WAIT_HI_RESP;
            s_d.inv_evt = 1'b1;
          end else begin
            s_d.resp = `SDC_INV_RESP;
            s_d.inv_evt = 1'b1;
          end
        end
        sdc_pkg::SDC_ST_ACTIVE: begin
          if (s_q.par_skip) begin
            // The command after a parity fault is dropped unexecuted.
            s_d.par_skip = 1'b0;
            s_d.resp = `SDC_INV_RESP;
          end else if (known && !par_good) begin
            s_d.par_skip = 1'b1;
            s_d.resp = `SDC_PAR_FAULT_WORD;
            s_d.par_evt = 1'b1;
          end else begin
            case (hdr)
              `SDC_HDR_PTR_WR: begin
                s_d.ptr = link_word[7:0];
                s_d.resp = sdc_reply(`SDC_RHDR_PTR, {`SDC_RMID_PTR, `SDC_BYTE_RST});
              end
              `SDC_HDR_PTR_RD: begin
                s_d.resp = sdc_reply(`SDC_RHDR_PTR, {`SDC_RMID_PTR, s_q.ptr});
              end
              `SDC_HDR_DAT_WR: begin
                s_d.wdata = link_word[7:0];
                s_d.we = 1'b1;
                s_d.resp = sdc_reply(`SDC_RHDR_DAT, {`SDC_RMID_DAT, s_q.ptr});
              end
              `SDC_HDR_DAT_RD: begin
                s_d.resp = sdc_reply(`SDC_RHDR_DAT, {`SDC_RMID_DAT, reg_rdata});
              end
              `SDC_HDR_ACC_RD: begin
                if (link_word[9:0] == `SDC_ACC_BODY_ZERO) begin
                  s_d.resp = sdc_reply(`SDC_RHDR_ACC, accel_data);
                end else begin
                  s_d.resp = `SDC_INV_RESP;
                  s_d.inv_evt = 1'b1;
                end
              end
              default: begin
                s_d.resp = `SDC_INV_RESP;
                s_d.inv_evt = 1'b1;
              end
            endcase
          end
        end
        sdc_pkg::SDC_ST_LOCKED: begin
          s_d.resp = `SDC_LOCK_RESP;
        end
        default: begin
          s_d.st = sdc_pkg::SDC_ST_WAIT;
          s_d.resp = `SDC_RESP_RST;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1, tg_s1: 1'b0, tg_s2: 1'b0,
               tg_seen: 1'b0, st: sdc_pkg::SDC_ST_WAIT, mode: 1'b0, locked: 1'b0,
               par_skip: 1'b0, ptr: `SDC_PTR_RST, wdata: `SDC_BYTE_RST, we: 1'b0,
               par_evt: 1'b0, inv_evt: 1'b0, resp: `SDC_RESP_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_addr = s_q.ptr;
  assign reg_wdata = s_q.wdata;
  assign reg_we = s_q.we;
  assign diag_program_mode = s_q.mode;
  assign entry_locked = s_q.locked;
  assign parity_fault = s_q.par_evt;
  assign invalid_cmd = s_q.inv_evt;

endmodule

// ===== sim/sdc_diag_checker.sv
// Port assertions for the SPI diagnostic command decoder.
module sdc_diag_checker (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic spi_cs_n,
  input wire logic spi_miso,
  input wire logic [7:0] reg_addr,
  input wire logic reg_we,
  input wire logic diag_program_mode,
  input wire logic entry_locked,
  input wire logic parity_fault,
  input wire logic invalid_cmd
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Chip select has just risen and is still passing through the synchroniser.
  sequence s_sync;
    $rose(spi_cs_n) ##1 spi_cs_n [*2];
  endsequence
  a_we_not_early: assert property (s_sync |-> !reg_we) else $error("early write");
  a_we_cs_high: assert property (reg_we |-> spi_cs_n && diag_program_mode)
    else $error("write out of place");
  a_we_one_cycle: assert property (reg_we |=> !reg_we) else $error("long write");
  a_mode_stays: assert property (diag_program_mode |=> diag_program_mode)
    else $error("mode dropped");
  a_lock_stays: assert property (entry_locked |=> entry_locked && !diag_program_mode)
    else $error("lock dropped");
  a_ptr_in_frame: assert property (!spi_cs_n |=> $stable(reg_addr))
    else $error("pointer moved");
  a_fault_alone: assert property (parity_fault |-> spi_cs_n && !reg_we ##1 !parity_fault)
    else $error("fault pulse");
  a_inv_no_change: assert property (invalid_cmd |-> !reg_we && $stable(reg_addr))
    else $error("invalid changed state");
  a_miso_idle: assert property (spi_cs_n |-> !spi_miso) else $error("miso idle");
endmodule

bind sdc_diag_decoder sdc_diag_checker chk (.sys_clk(sys_clk), .arst_n(arst_n),
  .spi_cs_n(spi_cs_n), .spi_miso(spi_miso), .reg_addr(reg_addr), .reg_we(reg_we),
  .diag_program_mode(diag_program_mode), .entry_locked(entry_locked),
  .parity_fault(parity_fault), .invalid_cmd(invalid_cmd));

// ===== sim/sdc_spi_master.sv
// Behavioural SPI master that sends mode-0 frames to the decoder.
module sdc_spi_master (
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // Clock idles low, runs only inside a frame, most significant bit first.
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = tx[i];
      #3;
      rx[i] = spi_miso;
      spi_sclk = 1'b1;
      #3;
      spi_sclk = 1'b0;
    end
    #3;
    spi_cs_n = 1'b1;
    // A released line must not keep showing the last bit.
    spi_mosi = ~tx[0];
    #80;
  endtask
endmodule

// ===== sim/test_spi_diag_command_decoder.sv
// Self-checking bench for the SPI diagnostic command decoder.
module test_spi_diag_command_decoder;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic sclk, cs_n, mosi, miso, we, mode, lock, pf, inv;
  logic [7:0] addr, wdat;
  logic [9:0] accel = 10'h2a5;
  logic [7:0] mem [256];
  logic [15:0] tx_tab [15];
  logic [15:0] rx_tab [15];
  logic [15:0] rx;
  int fails = 0;
  int n_tests = 0;
  int n_pf = 0;
  int n_inv = 0;
  int n_we = 0;
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (we) mem[addr] <= wdat;
  // Pulse outputs are counted so that each one is compared at least once.
  always @(posedge sys_clk) begin
    if (pf === 1'b1) n_pf++;
    if (inv === 1'b1) n_inv++;
    if (we === 1'b1) n_we++;
  end
  sdc_diag_decoder dut (.sys_clk(sys_clk), .arst_n(arst_n), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_mosi(mosi), .spi_miso(miso), .reg_addr(addr), .reg_wdata(wdat), .reg_we(we),
    .reg_rdata(mem[addr]), .accel_data(accel), .diag_program_mode(mode),
    .entry_locked(lock), .parity_fault(pf), .invalid_cmd(inv));
  sdc_spi_master m (.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso));
  function automatic logic [15:0] rsp(logic [4:0] h, logic [1:0] md, logic [7:0] b);
    logic [15:0] w;
    w = {h, 1'b0, md, b};
    w[10] = ~^w;
    return w;
  endfunction
  function automatic logic [15:0] wcmd(logic [4:0] h, logic [7:0] b);
    logic [15:0] w;
    w = {h, 3'h0, b};
    w[9] = ~^w;
    return w;
  endfunction
  function automatic logic [15:0] rcmd(logic [4:0] h);
    return {h, ~^h, 10'h000};
  endfunction
  task automatic check(logic [15:0] seen, logic [15:0] exp, string what);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic put(int i, logic [15:0] t, logic [15:0] e);
    tx_tab[i] = t;
    rx_tab[i] = e;
  endtask
  task automatic go(logic [15:0] tx);
    @(posedge sys_clk);
    #1 m.xfer(tx, rx);
  endtask
  task automatic do_reset(int n);
    @(posedge sys_clk);
    #1 arst_n = 1'b0;
    repeat (n) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    check({6'h00, lock, mode, addr}, 16'h0000, "reset");
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #60000;
    fails++;
    wrap_up;
  end
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    do_reset(16);
    put(0, 16'ha35c, 16'h0000);
    put(1, wcmd(5'h09, 8'h3c), ~16'ha35c);
    put(2, wcmd(5'h0b, 8'h5a), rsp(5'h16, 2'h1, 8'h00));
    put(3, rcmd(5'h08), rsp(5'h14, 2'h2, 8'h3c));
    put(4, rcmd(5'h0a), rsp(5'h16, 2'h1, 8'h3c));
    put(5, rcmd(5'h0c), rsp(5'h14, 2'h2, 8'h5a));
    put(6, wcmd(5'h09, 8'hff), rsp(5'h13, accel[9:8], accel[7:0]));
    put(7, wcmd(5'h0b, 8'h77) ^ 16'h0200, rsp(5'h16, 2'h1, 8'h00));
    put(8, rcmd(5'h0a), 16'h83ff);
    put(9, rcmd(5'h08), 16'h8000);
    put(10, rcmd(5'h0a), rsp(5'h16, 2'h1, 8'hff));
    put(11, 16'h0000, rsp(5'h14, 2'h2, 8'h00));
    put(12, rcmd(5'h08), 16'h8000);
    put(13, rcmd(5'h0c) | 16'h0001, rsp(5'h16, 2'h1, 8'hff));
    put(14, rcmd(5'h08), 16'h8000);
    for (int i = 0; i < 15; i++) begin
      go(tx_tab[i]);
      check(rx, rx_tab[i], "reply");
    end
    check(16'(n_pf), 16'h0001, "fault pulses");
    check(16'(n_inv), 16'h0002, "invalid pulses");
    check(16'(n_we), 16'h0001, "write pulses");
    do_reset(2);
    go(16'h0000);
    check(rx, 16'h0000, "reset reply");
    go(16'h6000);
    check(rx, 16'h8000, "wait 00");
    go(16'hc000);
    check(rx, 16'h8000, "wait 011");
    go(16'h8000);
    check(rx, 16'h0001, "wait 11");
    go(16'ha35c);
    check(rx, 16'h0000, "locked reply");
    go(16'h0000);
    check(rx, 16'h0000, "locked entry");
    check({14'h0000, lock, mode}, 16'h0002, "lock state");
    check(16'(n_inv), 16'h0005, "wait pulses");
    wrap_up;
  end
endmodule
